// ===== src/sba_adc_ctrl.sv
// Behaviour
// RULE1: 10-bit at up to 300 ksps, 12-bit at up to 75 ksps.
// RULE2: burst powers converter up, samples, accumulates, shuts down alone.
// RULE3: 16-bit accumulator sums oversampled conversion codes.
// RULE4: each completed result updates result high and low bytes.
// RULE5: justify select picks right or left justification across bytes.
// RULE6: repeat count one gives plain 10-bit unsigned result.
// RULE7: code spans zero to full scale in single-code steps.
// RULE8: bits unused by justification read as zero.
// RULE9: result bytes change only after repeat count samples summed.
`timescale 1ns/1ps
`default_nettype none
module sba_adc_ctrl
	import sba_pkg::*;
#(
	parameter int ACC_W = 16,
	parameter int RPT_W = 6
)
(
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire sba_bus_t   bus,
	output logic      [7:0] rdata,
	output logic            sar_power_on,
	output logic            sar_start,
	output logic            sar_res12,
	input  wire logic       sar_done,
	input  wire logic [11:0] sar_code
);
	initial
	begin
		if (ACC_W != 16 || RPT_W < 1 || RPT_W > 6)
			$error("sba_adc_ctrl: unsupported parameters");
	end

	logic [2:0]        ctrl_r, ctrl_nxt;
	logic [RPT_W-1:0]  rpt_r, rpt_nxt;
	logic [2:0]        just_r, just_nxt;
	logic [15:0]       prd_r, prd_nxt;
	sba_state_t        st_r, st_nxt;
	logic [ACC_W-1:0]  acc_r, acc_nxt;
	logic [RPT_W-1:0]  cnt_r, cnt_nxt;
	logic [15:0]       tmr_r, tmr_nxt;
	sba_result_t       res_r, res_nxt;
	logic [7:0]        rdata_nxt;
	logic              busy;

	// place an accumulated value into the two result bytes
	function automatic sba_result_t fmt(input logic [15:0] v,
		input logic [2:0] js, input logic r12);
		sba_result_t o;
		logic [15:0] w;
		w = v;
		if (js == SBA_JUST_LEFT)
			w = r12 ? {v[11:0], 4'h0} : {v[9:0], 6'h00}; // RULE5 RULE8
		o.hi = w[15:8];
		o.lo = w[7:0];
		return o;
	endfunction

	// shortest legal spacing between conversions for the chosen resolution
	function automatic logic [15:0] min_period(input logic r12);
		return r12 ? 16'(SBA_PERIOD12) : 16'(SBA_PERIOD10);
	endfunction

	assign busy = (st_r != SBA_IDLE);

	// register file; start bit self-clears once the sequencer leaves idle
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		rpt_nxt  = rpt_r;
		just_nxt = just_r;
		prd_nxt  = prd_r;
		if (busy)
			ctrl_nxt[SBA_CTRL_START] = 1'b0;
		if (bus.wr)
		begin
			case (bus.addr)
				SBA_REG_CTRL:   ctrl_nxt = bus.wdata[2:0];
				SBA_REG_RPT:    rpt_nxt  = (bus.wdata[RPT_W-1:0] == '0) ?
					RPT_W'(1) : bus.wdata[RPT_W-1:0];
				SBA_REG_JUST:   just_nxt = bus.wdata[2:0];
				SBA_REG_PRD_HI: prd_nxt[15:8] = bus.wdata;
				SBA_REG_PRD_LO: prd_nxt[7:0]  = bus.wdata;
				default:        ;
			endcase
		end
	end

	always_comb
	begin
		rdata_nxt = SBA_ZERO8;
		if (bus.rd)
		begin
			case (bus.addr)
				SBA_REG_CTRL:   rdata_nxt = {5'h00, ctrl_r};
				SBA_REG_RPT:    rdata_nxt = 8'(rpt_r);
				SBA_REG_JUST:   rdata_nxt = {5'h00, just_r};
				SBA_REG_STAT:   rdata_nxt = {3'h0, st_r};
				SBA_REG_RES_HI: rdata_nxt = res_r.hi; // RULE4
				SBA_REG_RES_LO: rdata_nxt = res_r.lo; // RULE4
				SBA_REG_PRD_HI: rdata_nxt = prd_r[15:8];
				SBA_REG_PRD_LO: rdata_nxt = prd_r[7:0];
				default:        rdata_nxt = SBA_ZERO8;
			endcase
		end
	end

	// burst sequencer
	always_comb
	begin
		logic [15:0] minp;
		logic [11:0] code;
		minp    = min_period(ctrl_r[SBA_CTRL_RES12]); // RULE1
		code    = ctrl_r[SBA_CTRL_RES12] ? sar_code :
			{2'b00, sar_code[9:0]}; // RULE6 RULE7
		st_nxt  = st_r;
		acc_nxt = acc_r;
		cnt_nxt = cnt_r;
		res_nxt = res_r;
		tmr_nxt = (tmr_r != 16'h0000) ? tmr_r - 16'h0001 : tmr_r;
		case (st_r)
			SBA_IDLE:
				if (ctrl_r[SBA_CTRL_START])
				begin
					st_nxt  = SBA_PWRUP; // RULE2
					tmr_nxt = 16'(SBA_PWRUP_CYC);
					acc_nxt = '0;
					cnt_nxt = '0;
				end
			SBA_PWRUP:
				if (tmr_r == 16'h0000)
				begin
					st_nxt  = SBA_CONV;
					tmr_nxt = (prd_r > minp) ? prd_r : minp; // RULE1
				end
			SBA_CONV:
				if (sar_done)
				begin
					acc_nxt = acc_r + ACC_W'(code); // RULE3
					cnt_nxt = cnt_r + RPT_W'(1);
					st_nxt  = SBA_ACCUM;
				end
			SBA_ACCUM:
				if (cnt_r == rpt_r)
				begin
					res_nxt = fmt(acc_r, just_r,
						ctrl_r[SBA_CTRL_RES12]); // RULE9 RULE4
					st_nxt  = SBA_DONE;
				end
				else if (tmr_r == 16'h0000)
				begin
					st_nxt  = SBA_CONV;
					tmr_nxt = (prd_r > minp) ? prd_r : minp;
				end
			SBA_DONE:
			begin
				acc_nxt = '0;
				cnt_nxt = '0;
				st_nxt  = SBA_IDLE; // RULE2
			end
			default: st_nxt = SBA_IDLE;
		endcase
	end

	assign sar_power_on = busy && (st_r != SBA_DONE); // RULE2
	assign sar_start    = (st_r == SBA_CONV);
	assign sar_res12    = ctrl_r[SBA_CTRL_RES12];

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_r <= '0;
			rpt_r  <= RPT_W'(SBA_RPT_RESET);
			just_r <= SBA_JUST_RIGHT;
			prd_r  <= '0;
			st_r   <= SBA_IDLE;
			acc_r  <= '0;
			cnt_r  <= '0;
			tmr_r  <= '0;
			res_r  <= '0;
			rdata  <= '0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			rpt_r  <= rpt_nxt;
			just_r <= just_nxt;
			prd_r  <= prd_nxt;
			st_r   <= st_nxt;
			acc_r  <= acc_nxt;
			cnt_r  <= cnt_nxt;
			tmr_r  <= tmr_nxt;
			res_r  <= res_nxt;
			rdata  <= rdata_nxt;
		end
	end

	sequence s_sample;
		st_r == SBA_CONV && sar_done;
	endsequence

	// power-up dwell: the timer also spends one cycle on zero
	sequence s_pwrup_wait;
		(st_r == SBA_PWRUP && sar_power_on) [*5];
	endsequence

	sequence s_finish;
		st_r == SBA_DONE ##1 st_r == SBA_IDLE && !sar_power_on;
	endsequence

	// cycles since the sequencer last entered conversion, for checks only
	logic [15:0] gap_r, gap_nxt;

	always_comb
	begin
		gap_nxt = gap_r;
		if (gap_r != 16'hFFFF)
			gap_nxt = gap_r + 16'h0001;
		if (st_nxt == SBA_CONV && st_r != SBA_CONV)
			gap_nxt = 16'h0000;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			gap_r <= '0;
		else
			gap_r <= gap_nxt;
	end

	a_accum_adds: assert property (@(posedge sys_clk) // RULE3
		disable iff (!resetn)
		s_sample |=> acc_r == $past(acc_r) + ACC_W'(ctrl_r[SBA_CTRL_RES12] ?
			$past(sar_code) : {2'b00, $past(sar_code[9:0])}))
		else $error("accumulator did not add the code");
	a_result_hold: assert property (@(posedge sys_clk) // RULE9
		disable iff (!resetn)
		st_r != SBA_ACCUM |=> $stable(res_r))
		else $error("result changed outside completion");
	a_result_count: assert property (@(posedge sys_clk) // RULE2
		disable iff (!resetn)
		st_r == SBA_ACCUM && cnt_r == rpt_r |=> s_finish)
		else $error("burst did not finish and shut down");
	a_burst_power: assert property (@(posedge sys_clk) // RULE2
		disable iff (!resetn)
		st_r == SBA_IDLE && ctrl_r[SBA_CTRL_START]
		|=> s_pwrup_wait ##1 st_r == SBA_CONV)
		else $error("power-up sequence wrong");
	a_left_zero: assert property (@(posedge sys_clk) // RULE8
		disable iff (!resetn)
		just_r == SBA_JUST_LEFT && !ctrl_r[SBA_CTRL_RES12] && st_r == SBA_DONE
		|-> res_r.lo[5:0] == 6'h00)
		else $error("unused left bits not zero");
	a_right_zero: assert property (@(posedge sys_clk) // RULE6
		disable iff (!resetn)
		just_r == SBA_JUST_RIGHT && rpt_r == RPT_W'(1) && st_r == SBA_DONE &&
		!ctrl_r[SBA_CTRL_RES12] |-> res_r.hi[7:2] == 6'h00)
		else $error("single sample exceeds 10 bits");
	a_rate_limit: assert property (@(posedge sys_clk) // RULE1
		disable iff (!resetn)
		st_r == SBA_ACCUM && cnt_r != rpt_r && tmr_r != 16'h0000
		|=> st_r == SBA_ACCUM)
		else $error("sample rate exceeded");
	a_read_result: assert property (@(posedge sys_clk) // RULE4
		disable iff (!resetn)
		bus.rd && bus.addr == SBA_REG_RES_HI |=> rdata == $past(res_r.hi))
		else $error("result high byte read wrong");
	a_code_range: assert property (@(posedge sys_clk) // RULE7
		disable iff (!resetn)
		(s_sample and !ctrl_r[SBA_CTRL_RES12]) |=>
		acc_r - $past(acc_r) <= ACC_W'(16'h03FF))
		else $error("10-bit code out of range");

	a_conv_spacing: assert property (@(posedge sys_clk) // RULE1
		disable iff (!resetn)
		st_r == SBA_ACCUM && st_nxt == SBA_CONV
		|-> gap_r >= min_period(ctrl_r[SBA_CTRL_RES12]))
		else $error("conversions closer than the minimum period");
	a_conv_power: assert property (@(posedge sys_clk) // RULE2
		disable iff (!resetn)
		st_r == SBA_CONV |-> sar_power_on && sar_start)
		else $error("converter not powered while converting");
	a_idle_off: assert property (@(posedge sys_clk) // RULE2
		disable iff (!resetn)
		st_r == SBA_IDLE |-> !sar_power_on && !sar_start)
		else $error("converter left on while idle");
	a_rdata_idle: assert property (@(posedge sys_clk) // RULE4
		disable iff (!resetn)
		!bus.rd |=> rdata == SBA_ZERO8)
		else $error("read data stands without a read");

	a_left12_zero: assert property (@(posedge sys_clk) // RULE8
		disable iff (!resetn)
		just_r == SBA_JUST_LEFT && ctrl_r[SBA_CTRL_RES12] && st_r == SBA_DONE
		|-> res_r.lo[3:0] == 4'h0)
		else $error("unused left bits not zero in 12-bit mode");
	a_right12_zero: assert property (@(posedge sys_clk) // RULE8
		disable iff (!resetn)
		just_r == SBA_JUST_RIGHT && rpt_r == RPT_W'(1) && st_r == SBA_DONE &&
		ctrl_r[SBA_CTRL_RES12] |-> res_r.hi[7:4] == 4'h0)
		else $error("single sample exceeds 12 bits");
endmodule
`default_nettype wire

// ===== src/sba_pkg.sv
package sba_pkg;
	// register index map, byte address = index (plain port, 8-bit data)
	localparam logic [3:0] SBA_REG_CTRL   = 4'h0;
	localparam logic [3:0] SBA_REG_RPT    = 4'h1;
	localparam logic [3:0] SBA_REG_JUST   = 4'h2;
	localparam logic [3:0] SBA_REG_STAT   = 4'h3;
	localparam logic [3:0] SBA_REG_RES_HI = 4'h4;
	localparam logic [3:0] SBA_REG_RES_LO = 4'h5;
	localparam logic [3:0] SBA_REG_PRD_HI = 4'h6;
	localparam logic [3:0] SBA_REG_PRD_LO = 4'h7;
	// control bit positions
	localparam int SBA_CTRL_START = 0;
	localparam int SBA_CTRL_BURST = 1;
	localparam int SBA_CTRL_RES12 = 2;
	// justification codes
	localparam logic [2:0] SBA_JUST_RIGHT = 3'h0;
	localparam logic [2:0] SBA_JUST_LEFT  = 3'h4;
	// repeat count reset value and converter timing
	localparam logic [5:0] SBA_RPT_RESET   = 6'h01;
	localparam int         SBA_CLK_HZ      = 50_000_000;
	localparam int         SBA_RATE10_SPS  = 300_000;
	localparam int         SBA_RATE12_SPS  = 75_000;
	localparam int         SBA_PERIOD10    = SBA_CLK_HZ / SBA_RATE10_SPS;
	localparam int         SBA_PERIOD12    = SBA_CLK_HZ / SBA_RATE12_SPS;
	localparam int         SBA_PWRUP_CYC   = 4;
	localparam logic [7:0] SBA_ZERO8       = 8'h00;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sba_bus_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} sba_result_t;

	typedef enum logic [4:0] {
		SBA_IDLE  = 5'b00001,
		SBA_PWRUP = 5'b00010,
		SBA_CONV  = 5'b00100,
		SBA_ACCUM = 5'b01000,
		SBA_DONE  = 5'b10000
	} sba_state_t;
endpackage

// ===== bench/sba_sar_model.sv
`timescale 1ns/1ps
`default_nettype none
module sba_sar_model
(
	input  wire logic        sys_clk,
	input  wire logic        sar_power_on,
	input  wire logic        sar_start,
	input  wire logic        sar_res12,
	input  wire logic [11:0] code_val,
	output logic             sar_done,
	output logic [11:0]      sar_code
);
	int          cnt = 0;
	logic [11:0] last = 12'h000;
	initial sar_done = 1'b0;
	initial sar_code = 12'hFFF;
	always @(posedge sys_clk)
	begin
		sar_done <= 1'b0;
		// stale code is inverted so it never passes for a fresh one
		sar_code <= ~last;
		if (sar_power_on && sar_start && !sar_done)
		begin
			cnt = cnt + 1;
			if (cnt == 3)
			begin
				cnt = 0;
				last = sar_res12 ? code_val : (code_val & 12'h3FF);
				sar_done <= 1'b1;
				sar_code <= last;
			end
		end
	end
endmodule
`default_nettype wire

// ===== bench/sba_adc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sba_adc_ctrl_tb;
	import sba_pkg::*;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	sba_bus_t    b = '0;
	logic [7:0]  rdata;
	logic        sar_power_on;
	logic        sar_start;
	logic        sar_res12;
	logic        sar_done;
	logic [11:0] sar_code;
	logic [11:0] code_val = 12'h000;
	int          miscompares = 0;
	int          n_compared = 0;
	initial forever #10 sys_clk = ~sys_clk;
	sba_adc_ctrl uut (.sys_clk(sys_clk), .resetn(resetn), .bus(b),
		.rdata(rdata), .sar_power_on(sar_power_on), .sar_start(sar_start),
		.sar_res12(sar_res12), .sar_done(sar_done), .sar_code(sar_code));
	sba_sar_model far (.sys_clk(sys_clk), .sar_power_on(sar_power_on),
		.sar_start(sar_start), .sar_res12(sar_res12), .code_val(code_val),
		.sar_done(sar_done), .sar_code(sar_code));
	task summarize;
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		b <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		b.wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		b <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		b.rd <= 1'b0;
		@(negedge sys_clk);
		chk(rdata, exp);
		// read data stands for one cycle only
		@(negedge sys_clk);
		chk(rdata, 8'h00);
	endtask
	// one whole burst: start, wait for shutdown, read both result bytes
	task burst(input logic [7:0] ctrl, input logic [11:0] code,
		input logic [7:0] hi, input logic [7:0] lo);
		int   i;
		logic seen;
		seen = 1'b0;
		code_val <= code;
		wr(SBA_REG_CTRL, ctrl);
		for (i = 0; i < 20000 && !(seen && sar_power_on === 1'b0); i++)
		begin
			@(negedge sys_clk);
			seen = seen | (sar_power_on === 1'b1);
		end
		if (i == 20000)
		begin
			miscompares++;
			summarize();
		end
		chk({7'h00, sar_res12}, {7'h00, ctrl[SBA_CTRL_RES12]});
		rd(SBA_REG_RES_HI, hi);
		rd(SBA_REG_RES_LO, lo);
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(SBA_REG_RPT, SBA_RPT_RESET);
		rd(4'h8, 8'h00);
		burst(8'h01, 12'h3FF, 8'h03, 8'hFF);
		rd(SBA_REG_CTRL, 8'h00);
		rd(SBA_REG_STAT, {3'h0, SBA_IDLE});
		wr(SBA_REG_JUST, SBA_JUST_LEFT);
		burst(8'h01, 12'h2A5, 8'hA9, 8'h40);
		burst(8'h05, 12'hABC, 8'hAB, 8'hC0);
		wr(SBA_REG_JUST, SBA_JUST_RIGHT);
		burst(8'h05, 12'hABC, 8'h0A, 8'hBC);
		rd(SBA_REG_CTRL, 8'h04);
		wr(SBA_REG_PRD_HI, 8'h03);
		wr(SBA_REG_PRD_LO, 8'h00);
		rd(SBA_REG_PRD_HI, 8'h03);
		rd(SBA_REG_PRD_LO, 8'h00);
		wr(SBA_REG_RPT, 8'h02);
		burst(8'h01, 12'h155, 8'h02, 8'hAA);
		// reset after the burst has shut down brings the settings back to their defaults
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(SBA_REG_PRD_HI, 8'h00);
		rd(SBA_REG_RES_HI, 8'h00);
		wr(SBA_REG_RPT, 8'h00);
		rd(SBA_REG_RPT, 8'h01);
		// 63 full-scale codes sum to 16'hFBC1, near the top of 16 bits
		wr(SBA_REG_RPT, 8'h3F);
		burst(8'h01, 12'h3FF, 8'hFB, 8'hC1);
		summarize();
	end
endmodule
`default_nettype wire
